// ---- inc/cd_input_pkg.sv ----
// Function
// - sync search selects sector mode, else audio
// - audio mode forwards samples to audio output
// - byte error flag used only in sector mode
// - data bit order configurable, msb or lsb
// - error flag order configurable like data
// - word sync delimits words, polarity selects left
// - accept 32, 48 or 64 bit clocks
// - mode 2 form 2 parsed without correction
// - mode 1, form 1 corrected when MPEG idle
// - mode 0 discarded, resume at next sync
// - Q-erasure, then P-erasure, then P-check
// - sub-header stored at fixed host-readable locations
// - mode byte must be 0x00, 0x01, 0x02
// - mode 2 file, channel, submode, coding stored
// - constant bit clock up to core/6
// - burst bit clock needs 3+3 core clocks
// - correction only while MPEG decoding inactive
// - reference timer counts audio master clock rising edges
// - host may force mode and data type
// - interface defaults at reset, changeable afterwards
package cd_input_pkg;

  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CONFIG_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] SCR_OFFSET = 8'h0c;
  localparam logic [7:0] COUNT_OFFSET = 8'h10;
  localparam logic [7:0] HDR_BASE = 8'h20;
  localparam logic [7:0] HDR_LAST = 8'h3c;

  localparam logic [15:0] SYNC_FIRST_WORD = 16'hff00;
  localparam logic [15:0] SYNC_MID_WORD = 16'hffff;
  localparam logic [15:0] SYNC_LAST_WORD = 16'h00ff;
  localparam logic [2:0] SYNC_LAST_POS = 3'h5;

  localparam logic [10:0] USER_START_M1 = 11'h002;
  localparam logic [10:0] USER_START_M2 = 11'h006;
  localparam logic [10:0] SECTOR_END = 11'h491;
  localparam logic [11:0] NOSYNC_WORDS = 12'h930;

  localparam logic [7:0] MODE0 = 8'h00;
  localparam logic [7:0] MODE1 = 8'h01;
  localparam logic [7:0] MODE2 = 8'h02;
  localparam int FORM2_BIT = 5;

  localparam logic [8:0] ECC_PHASE_CYCLES = 9'h100;
  localparam logic [11:0] ECC_MAX_ERASURES = 12'h002;

  // last member lands in bit 0 of the register
  typedef struct packed {
    logic ecc_en;
    logic force_sector;
    logic force_en;
  } ctrl_s;

  typedef struct packed {
    logic left_when_high;
    logic err_msb_first;
    logic data_msb_first;
  } cfg_s;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0] err;
    logic left;
  } word_s;

  localparam ctrl_s CTRL_RESET = '{force_en: 1'b0, force_sector: 1'b0, ecc_en: 1'b1};
  localparam cfg_s CFG_RESET = '{data_msb_first: 1'b1, err_msb_first: 1'b1, left_when_high: 1'b1};

  typedef enum logic [1:0] {ST_HUNT, ST_HEADER, ST_DATA} parse_e;
  typedef enum logic [1:0] {ECC_IDLE, ECC_Q_ERASE, ECC_P_ERASE, ECC_P_CHECK} ecc_e;

endpackage

// ---- hw/pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // sync reset
  input wire logic [WIDTH-1:0] async_i, // pins from outside
  output logic [WIDTH-1:0] sync_o // synchronised levels
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_o <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule

// ---- hw/serial_capture.sv ----
`timescale 1ns/100ps
module serial_capture (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // sync reset
  input wire logic serial_bit_clock_i, // bit clock pin
  input wire logic serial_bit_input_i, // data pin
  input wire logic byte_error_flag_input_i, // error flag pin
  input wire logic channel_word_sync_i, // word sync pin
  input wire cd_input_pkg::cfg_s cfg_i, // order and polarity
  output cd_input_pkg::word_s word_o, // captured word
  output logic word_valid_o // one-cycle pulse
);
  import cd_input_pkg::*;

  logic [3:0] pins;
  logic bck_d_reg;
  logic sync_d_reg;
  logic primed_reg;
  logic [15:0] data_sr_reg;
  logic [15:0] err_sr_reg;
  logic bck_rise;

  // two flops on every pin; edges are found on the clean copy only
  pin_sync #(.WIDTH(4)) u_pins (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({channel_word_sync_i, byte_error_flag_input_i, serial_bit_input_i, serial_bit_clock_i}),
    .sync_o(pins)
  );

  // needs the bit clock high and low for at least 3 core clocks each
  assign bck_rise = pins[0] & ~bck_d_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bck_d_reg <= 1'b0;
    end else begin
      bck_d_reg <= pins[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_sr_reg <= 16'h0000;
      err_sr_reg <= 16'h0000;
    end else if (bck_rise) begin
      data_sr_reg <= cfg_i.data_msb_first ? {data_sr_reg[14:0], pins[1]} : {pins[1], data_sr_reg[15:1]};
      err_sr_reg <= cfg_i.err_msb_first ? {err_sr_reg[14:0], pins[2]} : {pins[2], err_sr_reg[15:1]};
    end
  end

  // the last 16 bits before a sync change form the word, so longer slots just shift out padding
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_d_reg <= 1'b0;
      primed_reg <= 1'b0;
      word_o <= '0;
      word_valid_o <= 1'b0;
    end else begin
      word_valid_o <= 1'b0;
      if (bck_rise) begin
        sync_d_reg <= pins[3];
        primed_reg <= 1'b1;
        if (primed_reg && (pins[3] != sync_d_reg)) begin
          word_o.data <= data_sr_reg;
          word_o.err <= {|err_sr_reg[15:8], |err_sr_reg[7:0]};
          word_o.left <= (sync_d_reg == cfg_i.left_when_high);
          word_valid_o <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- hw/cd_serial_sector_input.sv ----
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/100ps
module cd_serial_sector_input (
  input wire logic clk_i, // core clock, 125 MHz
  input wire logic rst_i, // sync reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic serial_bit_clock_i, // disc bit clock
  input wire logic serial_bit_input_i, // disc serial data
  input wire logic byte_error_flag_input_i, // per-byte error flag
  input wire logic channel_word_sync_i, // left/right word sync
  input wire logic audio_master_clock_i, // audio master clock
  input wire logic mpeg_decoding_i, // MPEG decoder busy
  output logic [15:0] audio_data_o, // pass-through sample
  output logic audio_left_o, // sample is left channel
  output logic audio_valid_o, // sample strobe
  output logic [15:0] sector_data_o, // user data word
  output logic [1:0] sector_err_o, // byte error flags of word
  output logic sector_valid_o, // user data strobe
  output logic sector_done_o // end of sector pulse
);
  import cd_input_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations

  ctrl_s ctrl_reg;
  cfg_s cfg_reg;
  word_s word;
  logic word_valid;
  logic sector_mode;
  logic auto_sector_reg;
  logic [11:0] nosync_cnt_reg;
  logic [2:0] sync_pos_reg;
  logic [15:0] sync_expect;
  logic sync_match;
  logic sync_hit;
  parse_e state_reg;
  logic [10:0] wcnt_reg;
  logic [7:0] mode_reg;
  logic form2_reg;
  logic [10:0] user_start;
  logic [1:0] err_used;
  logic [7:0] hdr_mem [0:7];
  logic [11:0] erasure_cnt_reg;
  logic [15:0] sector_cnt_reg;
  ecc_e ecc_state_reg;
  logic [8:0] ecc_cnt_reg;
  logic ecc_pending_reg;
  logic ecc_fail_reg;
  logic ecc_needed;
  logic [0:0] amclk_sync;
  logic amclk_d_reg;
  logic [31:0] scr_reg;
  logic wb_req;
  logic [31:0] rd_next;

  ////////////////////////////////////////////////////////////////////////
  // serial capture

  serial_capture u_capture (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .serial_bit_clock_i(serial_bit_clock_i),
    .serial_bit_input_i(serial_bit_input_i),
    .byte_error_flag_input_i(byte_error_flag_input_i),
    .channel_word_sync_i(channel_word_sync_i),
    .cfg_i(cfg_reg),
    .word_o(word),
    .word_valid_o(word_valid)
  );

  ////////////////////////////////////////////////////////////////////////
  // sync search and mode selection

  always_comb begin
    if (sync_pos_reg == 3'h0) begin
      sync_expect = SYNC_FIRST_WORD;
    end else if (sync_pos_reg == SYNC_LAST_POS) begin
      sync_expect = SYNC_LAST_WORD;
    end else begin
      sync_expect = SYNC_MID_WORD;
    end
  end

  assign sync_match = (word.data == sync_expect);
  assign sync_hit = word_valid & sync_match & (sync_pos_reg == SYNC_LAST_POS);

  // search runs in both modes so that audio mode can fall back into sector mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_pos_reg <= 3'h0;
    end else if (word_valid) begin
      if (sync_match) begin
        sync_pos_reg <= (sync_pos_reg == SYNC_LAST_POS) ? 3'h0 : sync_pos_reg + 3'h1;
      end else begin
        sync_pos_reg <= (word.data == SYNC_FIRST_WORD) ? 3'h1 : 3'h0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_sector_reg <= 1'b0;
      nosync_cnt_reg <= 12'h000;
    end else if (sync_hit) begin
      auto_sector_reg <= 1'b1;
      nosync_cnt_reg <= 12'h000;
    end else if (word_valid) begin
      if (nosync_cnt_reg == NOSYNC_WORDS) begin
        auto_sector_reg <= 1'b0;
      end else begin
        nosync_cnt_reg <= nosync_cnt_reg + 12'h001;
      end
    end
  end

  assign sector_mode = ctrl_reg.force_en ? ctrl_reg.force_sector : auto_sector_reg;

  // flags mean nothing for audio samples
  assign err_used = sector_mode ? word.err : 2'b00;

  ////////////////////////////////////////////////////////////////////////
  // audio pass-through

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      audio_data_o <= 16'h0000;
      audio_left_o <= 1'b0;
      audio_valid_o <= 1'b0;
    end else begin
      audio_valid_o <= word_valid & ~sector_mode;
      if (word_valid && !sector_mode) begin
        audio_data_o <= word.data;
        audio_left_o <= word.left;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sector parser

  assign user_start = (mode_reg == MODE2) ? USER_START_M2 : USER_START_M1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_HUNT;
      wcnt_reg <= 11'h000;
      mode_reg <= MODE0;
      form2_reg <= 1'b0;
    end else if (!sector_mode && !sync_hit) begin
      // the sync that turns auto mode on must also start its sector
      state_reg <= ST_HUNT;
    end else if (word_valid) begin
      case (state_reg)
        ST_HUNT: begin
          if (sync_hit) begin
            state_reg <= ST_HEADER;
            wcnt_reg <= 11'h000;
          end
        end
        ST_HEADER: begin
          wcnt_reg <= wcnt_reg + 11'h001;
          if (wcnt_reg[0]) begin
            mode_reg <= word.data[15:8];
            form2_reg <= 1'b0;
            if (word.data[15:8] == MODE1 || word.data[15:8] == MODE2) begin
              state_reg <= ST_DATA;
            end else begin
              // mode 0 and bad mode bytes drop the sector; the next sync restarts
              state_reg <= ST_HUNT;
            end
          end
        end
        ST_DATA: begin
          wcnt_reg <= wcnt_reg + 11'h001;
          if (wcnt_reg == 11'h003 && mode_reg == MODE2) begin
            form2_reg <= word.data[FORM2_BIT];
          end
          if (wcnt_reg == SECTOR_END) begin
            state_reg <= ST_HUNT;
          end
        end
        default: begin
          state_reg <= ST_HUNT;
        end
      endcase
    end
  end

  // header bytes land two per word: minutes, seconds, frames, mode, then sub-header
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        hdr_mem[i] <= 8'h00;
      end
    end else if (word_valid && sector_mode) begin
      if (state_reg == ST_HEADER) begin
        hdr_mem[{wcnt_reg[1:0], 1'b0}] <= word.data[7:0];
        hdr_mem[{wcnt_reg[1:0], 1'b1}] <= word.data[15:8];
      end else if (state_reg == ST_DATA && mode_reg == MODE2 && wcnt_reg < 11'h004) begin
        hdr_mem[{wcnt_reg[1:0], 1'b0}] <= word.data[7:0];
        hdr_mem[{wcnt_reg[1:0], 1'b1}] <= word.data[15:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sector_data_o <= 16'h0000;
      sector_err_o <= 2'b00;
      sector_valid_o <= 1'b0;
      sector_done_o <= 1'b0;
    end else begin
      sector_valid_o <= 1'b0;
      sector_done_o <= 1'b0;
      if (word_valid && sector_mode && state_reg == ST_DATA) begin
        if (wcnt_reg >= user_start) begin
          sector_data_o <= word.data;
          sector_err_o <= err_used;
          sector_valid_o <= 1'b1;
        end
        sector_done_o <= (wcnt_reg == SECTOR_END);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erasure_cnt_reg <= 12'h000;
      sector_cnt_reg <= 16'h0000;
    end else if (word_valid && sector_mode) begin
      if (state_reg == ST_HEADER && !wcnt_reg[0]) begin
        erasure_cnt_reg <= 12'h000;
      end else if (state_reg == ST_DATA) begin
        erasure_cnt_reg <= erasure_cnt_reg + {11'h000, err_used[1]} + {11'h000, err_used[0]};
        if (wcnt_reg == SECTOR_END) begin
          sector_cnt_reg <= sector_cnt_reg + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // correction sequencer

  assign ecc_needed = (mode_reg == MODE1) || (mode_reg == MODE2 && !form2_reg);

  // a sector that ends while MPEG runs is passed on uncorrected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ecc_pending_reg <= 1'b0;
    end else if (sector_done_o) begin
      ecc_pending_reg <= ecc_needed & ctrl_reg.ecc_en & ~mpeg_decoding_i;
    end else if (ecc_state_reg != ECC_IDLE) begin
      ecc_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ecc_state_reg <= ECC_IDLE;
      ecc_cnt_reg <= 9'h000;
      ecc_fail_reg <= 1'b0;
    end else if (mpeg_decoding_i && ecc_state_reg != ECC_IDLE) begin
      ecc_state_reg <= ECC_IDLE;
    end else begin
      case (ecc_state_reg)
        ECC_IDLE: begin
          ecc_cnt_reg <= 9'h000;
          if (ecc_pending_reg) begin
            ecc_state_reg <= ECC_Q_ERASE;
          end
        end
        ECC_Q_ERASE: begin
          ecc_cnt_reg <= ecc_cnt_reg + 9'h001;
          if (ecc_cnt_reg == ECC_PHASE_CYCLES - 9'h001) begin
            ecc_cnt_reg <= 9'h000;
            ecc_state_reg <= ECC_P_ERASE;
          end
        end
        ECC_P_ERASE: begin
          ecc_cnt_reg <= ecc_cnt_reg + 9'h001;
          if (ecc_cnt_reg == ECC_PHASE_CYCLES - 9'h001) begin
            ecc_cnt_reg <= 9'h000;
            ecc_state_reg <= ECC_P_CHECK;
          end
        end
        ECC_P_CHECK: begin
          ecc_cnt_reg <= ecc_cnt_reg + 9'h001;
          if (ecc_cnt_reg == ECC_PHASE_CYCLES - 9'h001) begin
            ecc_fail_reg <= (erasure_cnt_reg > ECC_MAX_ERASURES);
            ecc_state_reg <= ECC_IDLE;
          end
        end
        default: begin
          ecc_state_reg <= ECC_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // system clock reference timer

  pin_sync #(.WIDTH(1)) u_amclk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(audio_master_clock_i),
    .sync_o(amclk_sync)
  );

  // timer rate tracks the audio master clock, so pitch changes follow it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amclk_d_reg <= 1'b0;
      scr_reg <= 32'h0000_0000;
    end else begin
      amclk_d_reg <= amclk_sync[0];
      if (amclk_sync[0] && !amclk_d_reg) begin
        scr_reg <= scr_reg + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
      cfg_reg <= CFG_RESET;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == CTRL_OFFSET) begin
        ctrl_reg <= wb_dat_i[2:0];
      end else if (wb_adr_i == CONFIG_OFFSET) begin
        cfg_reg <= wb_dat_i[2:0];
      end
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    if (wb_adr_i == CTRL_OFFSET) begin
      rd_next[2:0] = ctrl_reg;
    end else if (wb_adr_i == CONFIG_OFFSET) begin
      rd_next[2:0] = cfg_reg;
    end else if (wb_adr_i == STATUS_OFFSET) begin
      rd_next[0] = sector_mode;
      rd_next[1] = (ecc_state_reg != ECC_IDLE);
      rd_next[2] = ecc_fail_reg;
      rd_next[3] = form2_reg;
      rd_next[5:4] = state_reg;
      rd_next[7:6] = ecc_state_reg;
      rd_next[15:8] = mode_reg;
      rd_next[27:16] = erasure_cnt_reg;
    end else if (wb_adr_i == SCR_OFFSET) begin
      rd_next = scr_reg;
    end else if (wb_adr_i == COUNT_OFFSET) begin
      rd_next[15:0] = sector_cnt_reg;
    end else if (wb_adr_i >= HDR_BASE && wb_adr_i <= HDR_LAST && wb_adr_i[1:0] == 2'b00) begin
      rd_next[7:0] = hdr_mem[wb_adr_i[4:2]];
    end
  end

  // unmapped addresses still answer, reading zero and ignoring writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= rd_next;
    end
  end
endmodule

// ---- verif/cd_serial_sector_input_monitor.sv ----
`timescale 1ns/100ps
module cd_input_monitor (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic serial_bit_clock_i, // bit clock pin
  input wire logic audio_valid_o, // sample strobe
  input wire logic sector_valid_o, // word strobe
  input wire logic [1:0] sector_err_o, // byte flags
  input wire logic sector_done_o // sector end
);
  logic req;
  logic bck_reg;
  logic [7:0] since_rise_reg;
  assign req = wb_cyc_i && wb_stb_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  // pin edges seen raw here, the design sees them a few clocks later
  always_ff @(posedge clk_i) begin
    bck_reg <= serial_bit_clock_i;
    if (rst_i || (serial_bit_clock_i && !bck_reg)) begin
      since_rise_reg <= 8'h00;
    end else if (since_rise_reg != 8'hff) begin
      since_rise_reg <= since_rise_reg + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_ack_next: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_rdata_hold: assert property (!(req && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data moved without a read");
  a_reset_quiet: assert property ($past(rst_i) |-> !wb_ack_o && !audio_valid_o && !sector_valid_o && !sector_done_o)
    else $error("output active right after reset");
  a_mode_exclusive: assert property (audio_valid_o |-> !sector_valid_o)
    else $error("audio and sector strobes together");
  a_audio_single: assert property (audio_valid_o |=> !audio_valid_o)
    else $error("audio strobe longer than one cycle");
  a_sector_single: assert property (sector_valid_o |=> !sector_valid_o)
    else $error("sector strobe longer than one cycle");
  a_word_timing: assert property ((audio_valid_o || sector_valid_o) |-> since_rise_reg inside {[1:8]})
    else $error("word strobe not tied to a bit clock rise");
  a_err_with_word: assert property ($changed(sector_err_o) |-> sector_valid_o)
    else $error("byte flags changed between words");
  c_audio: cover property (audio_valid_o);
  c_sector_err: cover property (sector_valid_o && sector_err_o != 2'h0);
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule
bind cd_serial_sector_input cd_input_monitor mon (.*);

// ---- verif/disc_serial_source.sv ----
`timescale 1ns/100ps
module disc_serial_source (
  output logic serial_bit_clock_o, // bit clock
  output logic serial_bit_input_o, // data
  output logic byte_error_flag_input_o, // error flag
  output logic channel_word_sync_o // word sync
);
  logic msb_first = 1'h1;
  logic lr = 1'h0;
  initial begin
    serial_bit_clock_o = 1'h0;
    serial_bit_input_o = 1'h0;
    byte_error_flag_input_o = 1'h0;
    channel_word_sync_o = 1'h0;
  end
  // 16 bits per word, two words per sync period: 32 clocks; short bursts only
  task automatic send_word(input logic [15:0] w, input logic [1:0] e);
    int b;
    #3;
    lr = ~lr;
    for (int i = 0; i < 16; i++) begin
      b = msb_first ? 15 - i : i;
      serial_bit_input_o = w[b];
      byte_error_flag_input_o = e[b / 8];
      channel_word_sync_o = lr;
      #80 serial_bit_clock_o = 1'h1;
      #80 serial_bit_clock_o = 1'h0;
    end
    // released lines must not look like the last bit
    serial_bit_input_o = ~serial_bit_input_o;
    byte_error_flag_input_o = ~byte_error_flag_input_o;
  endtask
endmodule

// ---- verif/cd_serial_sector_input_bench.sv ----
`timescale 1ns/100ps
module cd_serial_sector_input_bench;
  import cd_input_pkg::*;
  typedef struct packed {logic we; logic [7:0] adr; logic [3:0] sel; logic [31:0] dat;} row_s;
  localparam row_s ROWS[8] = '{'{1'h0, CTRL_OFFSET, 4'hf, 32'h4}, '{1'h0, CONFIG_OFFSET, 4'hf, 32'h7},
    '{1'h1, CONFIG_OFFSET, 4'he, 32'h0}, '{1'h0, CONFIG_OFFSET, 4'hf, 32'h7}, '{1'h1, 8'hfc, 4'hf, 32'hffffffff},
    '{1'h0, 8'hfc, 4'hf, 32'h0}, '{1'h1, CTRL_OFFSET, 4'hf, 32'h1}, '{1'h0, CTRL_OFFSET, 4'hf, 32'h1}};
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, audio_master_clock_i, mpeg_decoding_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, scr;
  logic audio_left_o, audio_valid_o, sector_valid_o, sector_done_o;
  logic [15:0] audio_data_o, sector_data_o;
  logic [1:0] sector_err_o;
  logic [2:0] cfg;
  wire bck, sdat, sflag, wsync;
  int mismatches = 0;
  int n_tests = 0;
  logic [17:0] aq[$], sq[$];
  logic [15:0] wv[$];
  logic [1:0] ev[$];
  logic lv[$];
  logic [7:0] hdr[8] = '{8'h13, 8'h02, 8'h44, 8'h02, 8'h01, 8'h07, 8'h20, 8'h0f};
  cd_serial_sector_input uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .serial_bit_clock_i(bck), .serial_bit_input_i(sdat), .byte_error_flag_input_i(sflag),
    .channel_word_sync_i(wsync), .audio_master_clock_i(audio_master_clock_i), .mpeg_decoding_i(mpeg_decoding_i),
    .audio_data_o(audio_data_o), .audio_left_o(audio_left_o), .audio_valid_o(audio_valid_o),
    .sector_data_o(sector_data_o), .sector_err_o(sector_err_o), .sector_valid_o(sector_valid_o),
    .sector_done_o(sector_done_o));
  disc_serial_source src (.serial_bit_clock_o(bck), .serial_bit_input_o(sdat), .byte_error_flag_input_o(sflag),
    .channel_word_sync_o(wsync));
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (audio_valid_o) aq.push_back({1'h0, audio_left_o, audio_data_o});
    if (sector_valid_o) sq.push_back({sector_err_o, sector_data_o});
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // classic cycle; the slave decides when ack comes
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    rd = wb_dat_o;
    if (wb_ack_o !== 1'h1) begin
      mismatches++;
      report_and_stop();
    end
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask
  // a dummy word leads, so any half word left in the shifter is flushed out
  task automatic stream;
    while (ev.size() < wv.size()) ev.push_front(2'h0);
    lv.delete();
    src.send_word(16'h0000, 2'h0);
    foreach (wv[i]) begin
      src.send_word(wv[i], ev[i]);
      lv.push_back(src.lr);
      if (i == 0) begin
        aq.delete();
        sq.delete();
      end
    end
    src.send_word(16'h0000, 2'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i, audio_master_clock_i, mpeg_decoding_i} = 5'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    foreach (ROWS[i]) begin
      wb(ROWS[i].we, ROWS[i].adr, ROWS[i].sel, ROWS[i].dat);
      if (!ROWS[i].we) check("register", rd, ROWS[i].dat);
    end
    wb(1'h0, SCR_OFFSET, 4'hf, 32'h0);
    scr = rd;
    repeat (10) begin
      repeat (4) @(posedge clk_i);
      audio_master_clock_i <= ~audio_master_clock_i;
    end
    wb(1'h0, SCR_OFFSET, 4'hf, 32'h0);
    check("timer", rd - scr, 32'h5);
    // forced audio; flags must not matter here
    for (int k = 0; k < 2; k++) begin
      cfg = k ? 3'h0 : 3'h7;
      wb(1'h1, CONFIG_OFFSET, 4'hf, {29'h0, cfg});
      src.msb_first = cfg[0];
      wv = '{16'h1234, 16'hbeef, 16'h8001};
      ev = '{2'h3, 2'h0, 2'h2};
      stream();
      check("audio count", aq.size(), 32'h3);
      check("sector count", sq.size(), 32'h0);
      foreach (wv[i]) check("audio", aq[i], {1'h0, lv[i] == cfg[2], wv[i]});
    end
    wb(1'h1, CTRL_OFFSET, 4'hf, 32'h4);
    wb(1'h1, CONFIG_OFFSET, 4'hf, 32'h7);
    src.msb_first = 1'h1;
    wv = '{16'hff00, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h00ff, 16'h0213, 16'h0244,
      16'h0701, 16'h0f20, 16'h0701, 16'h0f20, 16'hab12, 16'hcd34};
    ev = '{2'h1, 2'h2};
    stream();
    check("form2 count", sq.size(), 32'h2);
    check("form2 word", sq[0], {2'h1, 16'hab12});
    check("form2 word", sq[1], {2'h2, 16'hcd34});
    foreach (hdr[i]) begin
      wb(1'h0, HDR_BASE + 8'(4 * i), 4'hf, 32'h0);
      check("header", rd & 32'hff, {24'h0, hdr[i]});
    end
    wb(1'h0, STATUS_OFFSET, 4'hf, 32'h0);
    check("status", rd & 32'hff09, 32'h0209);
    // a cut sector never reaches its end: forced audio drops it, then sector mode is forced
    wb(1'h1, CTRL_OFFSET, 4'hf, 32'h5);
    wb(1'h1, CTRL_OFFSET, 4'hf, 32'h7);
    wb(1'h0, CTRL_OFFSET, 4'hf, 32'h0);
    check("ctrl", rd, 32'h7);
    // mode 0 is dropped and the next sync starts a mode 1 sector
    wv = '{16'hff00, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h00ff, 16'h0213, 16'h0045, 16'h0000,
      16'h0000, 16'hff00, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h00ff, 16'h0214, 16'h0146,
      16'h5a5a, 16'ha5c3};
    ev = '{2'h3, 2'h0};
    stream();
    check("mode1 count", sq.size(), 32'h2);
    check("mode1 word", sq[0], {2'h3, 16'h5a5a});
    check("mode1 word", sq[1], {2'h0, 16'ha5c3});
    wb(1'h0, STATUS_OFFSET, 4'hf, 32'h0);
    check("mode byte", rd & 32'hff01, 32'h0101);
    report_and_stop();
  end
endmodule
